/* src/lcfc_top.sv */
/*
 * limit check and fail counter stage: four processing blocks, each adds
 * its display offset to the math result, tests it against lower and upper
 * limits and counts failures; registers on a plain strobe port.
 * assumes: measurement and trigger inputs come from logic on CLOCK_IN;
 * the speed-200 level comes from the acquisition side on the same clock.
 */
// The strobed register port and the register offsets are this design's own decisions.
// How it works
// RULE1: offset added after math result arrives
// RULE2: writing offset value switches offset enable on
// RULE3: host keeps offset within plus/minus hundred
// RULE4: reset sets offset to zero
// RULE5: offset enable off at reset, reads 1/0
// RULE6: enabling offset at speed 200 flags conflict
// RULE7: auto-clear on zeros counter every trigger
// RULE8: auto-clear off keeps counter across triggers
// RULE9: once mode zeros counter on first trigger
// RULE10: auto-clear mode on after reset
// RULE11: once mode query reads 1 until triggered
// RULE12: immediate clear zeros counter at once
// RULE13: fail flag is counter non-zero
// RULE14: each out-of-limit result adds one
// RULE15: result equal to limit passes
// RULE16: reset, clear, auto-clear on zero counter
// RULE17: counter wraps to zero past maximum
// RULE18: below lower limit fails
// RULE19: host keeps lower limit within spans
// RULE20: lower limit resets to minus ninety
// RULE21: unit code follows mode and relative settings
// RULE22: above upper limit fails
// RULE23: four independent processing blocks
// RULE24: sixteen-bit counter wraps naturally
`timescale 1ns/1ps
`include "lcfc_defines.svh"

module lcfc_top #(
    parameter int NB = `LCFC_NUM_BLOCKS,
    parameter int DW = `LCFC_DATA_W,
    parameter int CW = `LCFC_COUNT_W
) (
    input wire logic CLOCK_IN,
    input wire logic RESETN_IN,
    input wire logic [`LCFC_ADDR_W-1:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT,
    input wire logic SPEED_200_IN,
    input wire logic [NB-1:0] TRIG_IN,
    input wire logic MEAS_VALID_IN,
    input wire logic [1:0] MEAS_BLOCK_IN,
    input wire logic signed [DW-1:0] MEAS_VALUE_IN,
    output logic RESULT_VALID_OUT,
    output logic [1:0] RESULT_BLOCK_OUT,
    output logic signed [DW-1:0] RESULT_OUT,
    output logic [NB-1:0] FAIL_FLAG_OUT
);
    import lcfc_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    function automatic lcfc_unit_type unit_of(input logic [1:0] math,
        input logic ptav, input logic linear, input logic rel);
        logic power;
        power = !rel && !ptav && (math != LCFC_MATH_RATIO);
        if (power) begin
            unit_of = linear ? LCFC_UNIT_WATT : LCFC_UNIT_DBM;
        end else begin
            unit_of = linear ? LCFC_UNIT_PCT : LCFC_UNIT_DB;
        end
    endfunction : unit_of

    function automatic logic outside(input logic signed [DW-1:0] v,
        input logic signed [DW-1:0] lo, input logic signed [DW-1:0] hi);
        outside = (v < lo) || (v > hi);
    endfunction : outside

    // ****************************************
    // state
    // ****************************************
    logic [NB-1:0] off_en_r;
    logic [NB-1:0] lim_en_r;
    lcfc_clr_mode_type clr_mode_r [NB];
    logic [4:0] aux_r [NB];
    logic signed [DW-1:0] offset_r [NB];
    logic signed [DW-1:0] lower_r [NB];
    logic signed [DW-1:0] upper_r [NB];
    logic conflict_r;
    logic [31:0] rdata_r;
    logic s1_valid_r;
    logic [1:0] s1_blk_r;
    logic signed [DW-1:0] s1_value_r;
    logic [NB-1:0] fail_r;
    logic [CW-1:0] count [NB];
    logic [NB-1:0] auto_q;
    logic [NB-1:0] clear_pulse;
    logic [NB-1:0] rearm_pulse;

    // ****************************************
    // address decode
    // ****************************************
    logic is_global;
    logic [1:0] blk;
    logic [4:0] reg_off;
    logic wr_ctrl;
    logic wr_off;
    logic wr_lower;
    logic wr_upper;
    logic wr_cmd;
    logic wr_err;
    logic on_req;
    logic conflict_set;
    lcfc_clr_mode_type new_mode;
    logic signed [DW-1:0] off_sel;

    assign is_global = ADDR_IN[`LCFC_GLOBAL_BIT];
    assign blk = ADDR_IN[`LCFC_BLK_LSB+1:`LCFC_BLK_LSB];
    assign reg_off = ADDR_IN[4:0];
    assign wr_ctrl = WR_IN && !is_global && reg_off == `LCFC_REG_CTRL;
    assign wr_off = WR_IN && !is_global && reg_off == `LCFC_REG_OFFSET;
    assign wr_lower = WR_IN && !is_global && reg_off == `LCFC_REG_LOWER;
    assign wr_upper = WR_IN && !is_global && reg_off == `LCFC_REG_UPPER;
    assign wr_cmd = WR_IN && !is_global && reg_off == `LCFC_REG_CMD;
    assign wr_err = WR_IN && ADDR_IN == `LCFC_REG_ERROR;
    assign new_mode = lcfc_clr_mode_type'(
        WDATA_IN[`LCFC_CTRL_CLR_LSB+1:`LCFC_CTRL_CLR_LSB]);

    // an enable that goes from off to on, or a fresh offset value
    assign on_req = (wr_ctrl &&
        ((WDATA_IN[`LCFC_CTRL_OFF_EN] && !off_en_r[blk]) ||
         (WDATA_IN[`LCFC_CTRL_LIM_EN] && !lim_en_r[blk]))) || wr_off;
    assign conflict_set = on_req && SPEED_200_IN; // RULE6

    // ****************************************
    // configuration registers
    // ****************************************
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            off_en_r <= '0; // RULE5
            lim_en_r <= '0;
        end else if (wr_ctrl) begin
            if (!SPEED_200_IN || !WDATA_IN[`LCFC_CTRL_OFF_EN]) begin
                off_en_r[blk] <= WDATA_IN[`LCFC_CTRL_OFF_EN]; // RULE6
            end
            if (!SPEED_200_IN || !WDATA_IN[`LCFC_CTRL_LIM_EN]) begin
                lim_en_r[blk] <= WDATA_IN[`LCFC_CTRL_LIM_EN];
            end
        end else if (wr_off && !SPEED_200_IN) begin
            off_en_r[blk] <= 1'b1; // RULE2
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            for (int i = 0; i < NB; i++) begin
                clr_mode_r[i] <= LCFC_CLR_ON; // RULE10
                aux_r[i] <= '0;
            end
        end else if (wr_ctrl) begin
            if (new_mode != 2'h3) begin
                clr_mode_r[blk] <= new_mode;
            end
            aux_r[blk] <= WDATA_IN[`LCFC_CTRL_REL:`LCFC_CTRL_MATH_LSB];
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            for (int i = 0; i < NB; i++) begin
                offset_r[i] <= `LCFC_OFFSET_RST; // RULE4
                lower_r[i] <= `LCFC_LOWER_RST; // RULE20
                upper_r[i] <= `LCFC_UPPER_RST;
            end
        end else begin
            if (wr_off) begin
                offset_r[blk] <= WDATA_IN;
            end
            if (wr_lower) begin
                lower_r[blk] <= WDATA_IN;
            end
            if (wr_upper) begin
                upper_r[blk] <= WDATA_IN;
            end
        end
    end

    // sticky conflict flag: write one to clear, a new conflict wins
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            conflict_r <= 1'b0;
        end else if (conflict_set) begin
            conflict_r <= 1'b1; // RULE6
        end else if (wr_err && WDATA_IN[`LCFC_ERR_CONFLICT]) begin
            conflict_r <= 1'b0;
        end
    end

    // ****************************************
    // clear strobes to the counters
    // ****************************************
    always_comb begin
        clear_pulse = '0;
        rearm_pulse = '0;
        if (wr_cmd && WDATA_IN[`LCFC_CMD_CLEAR]) begin
            clear_pulse[blk] = 1'b1; // RULE12
        end
        if (wr_ctrl && new_mode == LCFC_CLR_ON) begin
            clear_pulse[blk] = 1'b1; // RULE16
        end
        if (wr_ctrl && new_mode == LCFC_CLR_ONCE) begin
            rearm_pulse[blk] = 1'b1;
        end
    end

    // ****************************************
    // datapath
    // ****************************************
    assign off_sel = off_en_r[MEAS_BLOCK_IN] ? offset_r[MEAS_BLOCK_IN] : '0;

    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            s1_valid_r <= 1'b0;
            s1_blk_r <= '0;
            s1_value_r <= '0;
        end else begin
            s1_valid_r <= MEAS_VALID_IN;
            if (MEAS_VALID_IN) begin
                s1_blk_r <= MEAS_BLOCK_IN;
                s1_value_r <= MEAS_VALUE_IN + off_sel; // RULE1
            end
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            fail_r <= '0;
        end else begin
            for (int i = 0; i < NB; i++) begin
                fail_r[i] <= s1_valid_r && s1_blk_r == 2'(i) &&
                    lim_en_r[i] &&
                    outside(s1_value_r, lower_r[i], upper_r[i]);
                    // RULE15 RULE18 RULE22
            end
        end
    end

    for (genvar g = 0; g < NB; g++) begin : g_blk // RULE23
        lcfc_fail_unit #(.COUNT_W(CW)) u_fail (
            .clock_in(CLOCK_IN),
            .resetn_in(RESETN_IN),
            .mode_in(clr_mode_r[g]),
            .trig_in(TRIG_IN[g]),
            .fail_in(fail_r[g]),
            .clear_in(clear_pulse[g]),
            .rearm_in(rearm_pulse[g]),
            .count_out(count[g]),
            .auto_query_out(auto_q[g])
        );
        assign FAIL_FLAG_OUT[g] = count[g] != '0; // RULE13
    end

    assign RESULT_VALID_OUT = s1_valid_r;
    assign RESULT_BLOCK_OUT = s1_blk_r;
    assign RESULT_OUT = s1_value_r;

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rdata_r <= '0;
        end else if (!RD_IN) begin
            rdata_r <= '0;
        end else if (is_global) begin
            rdata_r <= (ADDR_IN == `LCFC_REG_ERROR) ?
                {31'h0000_0000, conflict_r} : '0;
        end else begin
            unique case (reg_off)
                `LCFC_REG_CTRL: rdata_r <= {23'h00_0000, aux_r[blk],
                    clr_mode_r[blk], lim_en_r[blk], off_en_r[blk]};
                `LCFC_REG_OFFSET: rdata_r <= offset_r[blk];
                `LCFC_REG_LOWER: rdata_r <= lower_r[blk];
                `LCFC_REG_UPPER: rdata_r <= upper_r[blk];
                `LCFC_REG_COUNT: rdata_r <= {{(32-CW){1'b0}}, count[blk]};
                `LCFC_REG_STATUS: rdata_r <= {26'h000_0000,
                    unit_of(aux_r[blk][1:0], aux_r[blk][2],
                        aux_r[blk][3], aux_r[blk][4]), // RULE21
                    1'b0, off_en_r[blk], auto_q[blk], // RULE5 RULE11
                    FAIL_FLAG_OUT[blk]}; // RULE13
                default: rdata_r <= '0;
            endcase
        end
    end

    assign RDATA_OUT = rdata_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESETN_IN);

    a_offset_applied: assert property ( // RULE1
        MEAS_VALID_IN |=> RESULT_VALID_OUT &&
        RESULT_OUT == $past(MEAS_VALUE_IN) + $past(off_sel))
        else $error("offset not added to result");
    a_offset_enable: assert property ( // RULE2
        wr_off && !SPEED_200_IN |=> off_en_r[$past(blk)])
        else $error("offset write left enable off");
    a_conflict_flag: assert property ( // RULE6
        wr_off && SPEED_200_IN && !off_en_r[blk]
        |=> conflict_r && !off_en_r[$past(blk)])
        else $error("speed conflict not flagged");
    a_reset_defaults: assert property ( // RULE4 RULE10 RULE20
        $rose(RESETN_IN) |-> offset_r[0] == `LCFC_OFFSET_RST &&
        lower_r[3] == `LCFC_LOWER_RST && clr_mode_r[1] == LCFC_CLR_ON &&
        off_en_r == '0 && FAIL_FLAG_OUT == '0)
        else $error("bad state after reset");
    a_limit_equal: assert property ( // RULE15
        s1_valid_r && (s1_value_r == lower_r[s1_blk_r] ||
        s1_value_r == upper_r[s1_blk_r]) |=> fail_r == '0)
        else $error("result on a limit failed");
    a_limit_outside: assert property ( // RULE18 RULE22
        s1_valid_r && lim_en_r[s1_blk_r] &&
        (s1_value_r < lower_r[s1_blk_r] || s1_value_r > upper_r[s1_blk_r])
        |=> fail_r[$past(s1_blk_r)])
        else $error("out-of-limit result passed");
    a_fail_query: assert property ( // RULE13
        RD_IN && !is_global && reg_off == `LCFC_REG_STATUS
        |=> RDATA_OUT[0] == ($past(count[blk]) != '0))
        else $error("fail flag read mismatch");
    a_autoclr_write: assert property ( // RULE16
        wr_ctrl && new_mode == LCFC_CLR_ON && !fail_r[blk]
        |=> count[$past(blk)] == '0)
        else $error("auto-clear on write kept counter");
    c_conflict: cover property (conflict_set);
    c_fail: cover property (|fail_r);
    c_offset_used: cover property (MEAS_VALID_IN && off_sel != '0);

endmodule : lcfc_top

/* src/lcfc_defines.svh */
/*
 * constants for the limit check and fail counter stage: register map,
 * field positions, reset values.
 * assumes: included by bare name; values are signed milli-dB (or milli-%).
 */
`ifndef LCFC_DEFINES_SVH
`define LCFC_DEFINES_SVH

// ****************************************
// geometry
// ****************************************
`define LCFC_NUM_BLOCKS 4
`define LCFC_DATA_W 32
`define LCFC_ADDR_W 8
`define LCFC_COUNT_W 16

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define LCFC_BLK_LSB 5
`define LCFC_GLOBAL_BIT 7
`define LCFC_REG_CTRL 5'h00
`define LCFC_REG_OFFSET 5'h04
`define LCFC_REG_LOWER 5'h08
`define LCFC_REG_UPPER 5'h0C
`define LCFC_REG_COUNT 5'h10
`define LCFC_REG_STATUS 5'h14
`define LCFC_REG_CMD 5'h18
`define LCFC_REG_ERROR 8'h80

// ****************************************
// control fields
// ****************************************
`define LCFC_CTRL_OFF_EN 0
`define LCFC_CTRL_LIM_EN 1
`define LCFC_CTRL_CLR_LSB 2
`define LCFC_CTRL_MATH_LSB 4
`define LCFC_CTRL_PTAV 6
`define LCFC_CTRL_LINEAR 7
`define LCFC_CTRL_REL 8

// ****************************************
// status, command and error fields
// ****************************************
`define LCFC_STAT_FAIL 0
`define LCFC_STAT_AUTO 1
`define LCFC_STAT_OFF_EN 2
`define LCFC_STAT_UNIT_LSB 4
`define LCFC_CMD_CLEAR 0
`define LCFC_ERR_CONFLICT 0

// ****************************************
// reset values
// ****************************************
`define LCFC_OFFSET_RST 32'h0000_0000
`define LCFC_LOWER_RST 32'hFFFE_A070
`define LCFC_UPPER_RST 32'h0001_5F90

`endif

/* src/lcfc_pkg.sv */
/*
 * types of the limit check and fail counter stage.
 * assumes: nothing beyond the defines header.
 */
package lcfc_pkg;

    typedef enum logic [1:0] {
        LCFC_CLR_OFF = 2'h0,
        LCFC_CLR_ON = 2'h1,
        LCFC_CLR_ONCE = 2'h2
    } lcfc_clr_mode_type;

    typedef enum logic [1:0] {
        LCFC_UNIT_WATT = 2'h0,
        LCFC_UNIT_DBM = 2'h1,
        LCFC_UNIT_PCT = 2'h2,
        LCFC_UNIT_DB = 2'h3
    } lcfc_unit_type;

    typedef enum logic [1:0] {
        LCFC_MATH_SINGLE = 2'h0,
        LCFC_MATH_RATIO = 2'h1,
        LCFC_MATH_DIFF = 2'h2
    } lcfc_math_type;

endpackage : lcfc_pkg

/* src/lcfc_fail_unit.sv */
/*
 * fail counter of one processing block with its auto-clear modes.
 * assumes: all strobes are one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
`include "lcfc_defines.svh"

module lcfc_fail_unit #(
    parameter int COUNT_W = `LCFC_COUNT_W
) (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire lcfc_pkg::lcfc_clr_mode_type mode_in,
    input wire logic trig_in,
    input wire logic fail_in,
    input wire logic clear_in,
    input wire logic rearm_in,
    output logic [COUNT_W-1:0] count_out,
    output logic auto_query_out
);
    import lcfc_pkg::*;

    logic [COUNT_W-1:0] count_r;
    logic once_done_r;
    logic zero_on_trig;

    // ****************************************
    // counter
    // ****************************************
    assign zero_on_trig = (mode_in == LCFC_CLR_ON) ||
        ((mode_in == LCFC_CLR_ONCE) && !once_done_r); // RULE7 RULE8 RULE9

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            count_r <= '0; // RULE16
        end else if (clear_in || (trig_in && zero_on_trig)) begin
            // a failure in the clearing cycle still counts
            count_r <= {{(COUNT_W-1){1'b0}}, fail_in}; // RULE12
        end else if (fail_in) begin
            count_r <= count_r + COUNT_W'(1); // RULE14 RULE17 RULE24
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            once_done_r <= 1'b0;
        end else if (rearm_in) begin
            once_done_r <= 1'b0;
        end else if (trig_in && mode_in == LCFC_CLR_ONCE) begin
            once_done_r <= 1'b1; // RULE9
        end
    end

    assign count_out = count_r;
    assign auto_query_out = (mode_in == LCFC_CLR_ON) ||
        ((mode_in == LCFC_CLR_ONCE) && !once_done_r); // RULE11

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    a_auto_clear_on: assert property ( // RULE7
        trig_in && mode_in == LCFC_CLR_ON && !fail_in
        |=> count_r == '0)
        else $error("auto-clear on did not zero counter");
    a_clear_off_keeps: assert property ( // RULE8
        trig_in && mode_in == LCFC_CLR_OFF && !fail_in && !clear_in
        |=> $stable(count_r))
        else $error("auto-clear off changed counter");
    a_once_then_hold: assert property ( // RULE9
        trig_in && mode_in == LCFC_CLR_ONCE && once_done_r && !fail_in &&
        !clear_in && !rearm_in
        |=> $stable(count_r) && !auto_query_out)
        else $error("once mode cleared twice");
    a_imm_clear: assert property ( // RULE12
        clear_in && !fail_in |=> count_r == '0)
        else $error("immediate clear missed");
    a_fail_count: assert property ( // RULE14
        fail_in && !clear_in && !(trig_in && zero_on_trig)
        |=> count_r == $past(count_r) + COUNT_W'(1))
        else $error("failure not counted");
    c_wrap: cover property (
        fail_in && count_r == '1 && !clear_in ##1 count_r == '0);
    c_once: cover property (
        trig_in && mode_in == LCFC_CLR_ONCE && !once_done_r);

endmodule : lcfc_fail_unit

/* dv/lcfc_meas_model.sv */
/*
 * partner model: acquisition side feeding math results and triggers.
 * assumes: shares the stage clock; drives right after rising edges.
 */
`timescale 1ns/1ps

module lcfc_meas_model (
    input wire logic clk_in,
    output logic [3:0] trig_out,
    output logic valid_out,
    output logic [1:0] block_out,
    output logic signed [31:0] value_out
);
    initial begin
        trig_out = 4'h0;
        valid_out = 1'b0;
        block_out = 2'h0;
        value_out = 32'h0000_0000;
    end

    // ****************************************
    // math result stream, n results in a row
    // ****************************************
    task automatic send(input logic [1:0] b, input logic [31:0] x,
                        input int n);
        @(posedge clk_in);
        valid_out <= 1'b1;
        block_out <= b;
        value_out <= x;
        repeat (n) @(posedge clk_in);
        valid_out <= 1'b0;
        value_out <= ~x;
    endtask : send

    // ****************************************
    // one-cycle measurement trigger
    // ****************************************
    task automatic trig(input int b);
        @(posedge clk_in);
        trig_out <= 4'h1 << b;
        @(posedge clk_in);
        trig_out <= 4'h0;
    endtask : trig
endmodule : lcfc_meas_model

/* dv/limit_check_fail_counter_test.sv */
/*
 * self-checking bench of the limit check and fail counter stage.
 * assumes: lcfc_top with default parameters, lcfc_meas_model partner.
 */
`timescale 1ns/1ps

`define CHK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
end

module limit_check_fail_counter_test;
    logic clk, rst_n, wr, rd, speed, rv;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rres;
    logic [3:0] trig, ff;
    logic mv;
    logic [1:0] mb, rb;
    logic signed [31:0] mval;
    int fails, n_tests, cyc;
    logic [31:0] lv[4] = '{32'hFFFE_A070, 32'hFFFE_A06F,
                           32'h0001_5F90, 32'h0001_5F91};
    logic [31:0] cv[7] = '{32'h0, 32'h80, 32'h10, 32'h90, 32'h100, 32'h40,
                           32'h20};
    logic [31:0] ue[7] = '{32'h10, 32'h0, 32'h30, 32'h20, 32'h30, 32'h30,
                           32'h10};

    lcfc_top u_dut (.CLOCK_IN(clk), .RESETN_IN(rst_n), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .SPEED_200_IN(speed), .TRIG_IN(trig), .MEAS_VALID_IN(mv),
        .MEAS_BLOCK_IN(mb), .MEAS_VALUE_IN(mval), .RESULT_VALID_OUT(rv),
        .RESULT_BLOCK_OUT(rb), .RESULT_OUT(rres), .FAIL_FLAG_OUT(ff));

    lcfc_meas_model m (.clk_in(clk), .trig_out(trig), .valid_out(mv),
        .block_out(mb), .value_out(mval));

    // ****************************************
    // clock, timeout, bus tasks
    // ****************************************
    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrr

    task automatic rdc(input logic [7:0] a, input logic [31:0] msk,
                       input logic [31:0] e, input string nm);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(nm, e, rdata & msk)
    endtask : rdc

    task automatic settle();
        repeat (4) @(posedge clk);
    endtask : settle

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // ****************************************
    // tests
    // ****************************************
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        speed = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rdc(8'h00, '1, 32'h0000_0004, "ctrl");
        rdc(8'h04, '1, 32'h0000_0000, "offset");
        rdc(8'h08, '1, 32'hFFFE_A070, "lower");
        rdc(8'h0C, '1, 32'h0001_5F90, "upper");
        rdc(8'h10, '1, 32'h0000_0000, "count");
        rdc(8'h14, '1, 32'h0000_0012, "status");
        rdc(8'h1C, '1, 32'h0000_0000, "unmapped");
        `CHK("flags", 4'h0, ff)
        $display("test reset done");
        wrr(8'h24, 32'h0000_4E20);
        rdc(8'h20, 32'h1, 32'h1, "offset enable");
        m.send(2'd1, 32'hFFFF_EC78, 1);
        #1;
        `CHK("result", 32'h0000_3A98, rres)
        `CHK("result block", 2'd1, rb)
        `CHK("result valid", 1'b1, rv)
        $display("test offset done");
        wrr(8'h00, 32'h0000_0002);
        for (int i = 0; i < 4; i++) begin
            m.send(2'd0, lv[i], 1);
        end
        settle();
        rdc(8'h10, '1, 32'h0000_0002, "count");
        `CHK("flags", 4'h1, ff)
        rdc(8'h30, '1, 32'h0000_0000, "other count");
        m.trig(0);
        settle();
        rdc(8'h10, '1, 32'h0000_0002, "count");
        wrr(8'h18, 32'h0000_0001);
        rdc(8'h10, '1, 32'h0000_0000, "count");
        `CHK("flags", 4'h0, ff)
        $display("test limits done");
        wrr(8'h00, 32'h0000_000A);
        rdc(8'h14, 32'h2, 32'h2, "query");
        m.send(2'd0, lv[1], 1);
        settle();
        m.trig(0);
        settle();
        rdc(8'h10, '1, 32'h0000_0000, "count");
        rdc(8'h14, 32'h2, 32'h0, "query");
        m.send(2'd0, lv[3], 1);
        settle();
        m.trig(0);
        settle();
        rdc(8'h10, '1, 32'h0000_0001, "count");
        wrr(8'h00, 32'h0000_0006);
        rdc(8'h10, '1, 32'h0000_0000, "count");
        m.send(2'd0, lv[3], 1);
        settle();
        rdc(8'h10, '1, 32'h0000_0001, "count");
        m.trig(0);
        settle();
        rdc(8'h10, '1, 32'h0000_0000, "count");
        $display("test auto clear done");
        @(posedge clk);
        speed <= 1'b1;
        wrr(8'h44, 32'h0000_1388);
        rdc(8'h44, '1, 32'h0000_1388, "offset kept");
        rdc(8'h80, 32'h1, 32'h1, "conflict");
        wrr(8'h80, 32'h0000_0001);
        wrr(8'h40, 32'h0000_0001);
        rdc(8'h40, 32'h1, 32'h0, "refused enable");
        rdc(8'h80, 32'h1, 32'h1, "conflict");
        @(posedge clk);
        speed <= 1'b0;
        wrr(8'h80, 32'h0000_0001);
        rdc(8'h80, 32'h1, 32'h0, "conflict");
        for (int i = 0; i < 7; i++) begin
            wrr(8'h40, cv[i]);
            rdc(8'h54, 32'h30, ue[i], "unit");
        end
        $display("test conflict and units done");
        wrr(8'h68, 32'hFFFD_B610);
        rdc(8'h68, '1, 32'hFFFD_B610, "lower");
        wrr(8'h60, 32'h0000_0002);
        m.send(2'd3, 32'h0003_0D40, 65535);
        settle();
        rdc(8'h70, '1, 32'h0000_FFFF, "count");
        m.send(2'd3, 32'h0003_0D40, 1);
        settle();
        rdc(8'h70, '1, 32'h0000_0000, "count");
        `CHK("flags", 4'h0, ff)
        $display("test wrap done");
        m.send(2'd3, 32'h0003_0D40, 1);
        settle();
        `CHK("flags", 4'h8, ff)
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(8'h70, '1, 32'h0000_0000, "count");
        rdc(8'h68, '1, 32'hFFFE_A070, "lower");
        `CHK("flags", 4'h0, ff)
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule : limit_check_fail_counter_test
